// ===== dgp_pkg.sv
// ****************************************************************
// Shared constants for the dual general purpose port
// ****************************************************************
package dgp_pkg;

	// ****************************************************************
	// Register indices; byte address is four times the index
	// ****************************************************************
	localparam logic [5:0] IDX_A_LATCH      = 6'h00; // port_a_latch
	localparam logic [5:0] IDX_B_LATCH      = 6'h01; // port_b_latch
	localparam logic [5:0] IDX_A_DIRECTION  = 6'h04; // port_a_direction
	localparam logic [5:0] IDX_B_DIR_SLEW   = 6'h05; // port_b_direction_slew
	localparam logic [5:0] IDX_A_PULLUP     = 6'h10; // port_a_pullup_enable
	localparam logic [5:0] IDX_B_PULLUP     = 6'h11; // port_b_pullup_enable
	localparam logic [5:0] IDX_IRQ_STATUS   = 6'h20; // Sticky event flags
	localparam logic [5:0] IDX_IRQ_MASK     = 6'h21; // Event enables
	localparam logic [5:0] IDX_CONVERTER    = 6'h22; // Analog channel control

	// ****************
	// Widths
	// ****************
	localparam int WIDE_PINS   = 8; // Eight-bit port
	localparam int NARROW_PINS = 5; // Five-bit port
	localparam int EVENT_BITS  = 3; // Interrupt status width

	// ****************
	// Field positions
	// ****************
	localparam int SLOW_UPPER_A_BIT = 7; // slow_edge_enable_upper_a
	localparam int SLOW_ALL_B_BIT   = 6; // slow_edge_enable_all_b
	localparam int EVT_MAIN_BIT     = 0; // Main external interrupt request rose
	localparam int EVT_SECOND_BIT   = 1; // Second external interrupt request rose
	localparam int EVT_CAPTURE_BIT  = 2; // Capture input changed
	localparam int CONV_ON_BIT      = 0; // converter_power_on
	localparam int CONV_CH4_BIT     = 1; // analog_channel_four selected
	localparam int CONV_CH5_BIT     = 2; // analog_channel_five selected
	localparam int CH4_PIN          = 3; // narrow_port_pin_three
	localparam int CH5_PIN          = 4; // narrow_port_pin_four

	// ****************************************************************
	// Reset values and bus answers
	// ****************************************************************
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLV  = 2'b10;

endpackage : dgp_pkg

// ===== dgp_pin_bank.sv
`timescale 1ns/1ps
`default_nettype none
// One port worth of pin cells: sampling, pad drive and read-back
module dgp_pin_bank #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pinIn,        // Pad level
	input  wire logic [WIDTH-1:0] latchVal,     // Output latch
	input  wire logic [WIDTH-1:0] dirVal,       // Stored direction bits
	input  wire logic [WIDTH-1:0] pullVal,      // Stored pull-up enables
	input  wire logic [WIDTH-1:0] analogForce,  // Pins taken by the converter
	output logic      [WIDTH-1:0] sampled,      // Registered pad level
	output logic      [WIDTH-1:0] effDir,       // Direction after analog forcing
	output logic      [WIDTH-1:0] readVal,      // Value seen by a register read
	output logic      [WIDTH-1:0] padOut,       // Pad output level
	output logic      [WIDTH-1:0] padOutEn_n,   // Low while the pad is driven
	output logic      [WIDTH-1:0] padPullUp     // Pull-up resistor switch
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [WIDTH-1:0] smp; // Pad sample
	} dgp_bank_t;

	dgp_bank_t state;      // Registered state
	dgp_bank_t next_state; // Next value

	// R15 - sample pins synchronously
	always_comb begin
		next_state     = state;
		next_state.smp = pinIn;
	end

	// Sample register; starts at the idle-high pin level so that
	// no false request or capture edge follows reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= '1;
		end else begin
			state <= next_state;
		end
	end

	assign sampled = state.smp;

	// R14 - converter forces input
	assign effDir = dirVal & ~analogForce;

	// R11 - outputs read latch
	assign readVal = (effDir & latchVal) | (~effDir & state.smp);

	// R7 - four pin configurations
	// R4 - one means output
	// Open drain only sinks: the pull-up supplies the high level
	assign padOut     = latchVal & ~pullVal;
	assign padOutEn_n = ~(effDir & (~pullVal | ~latchVal));

	// R14 - pull-up off when analog
	assign padPullUp = pullVal & ~analogForce;

endmodule : dgp_pin_bank
`default_nettype wire

// ===== dgp_port.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - eight-bit port, latch 0x00, direction 0x04
// R2 - five-bit port, latch 0x01, direction 0x05
// R3 - reset keeps latches, clears directions
// R4 - direction one output, zero input
// R5 - eight-bit pull-ups written at 0x10
// R6 - five-bit pull-ups written at 0x11
// R7 - pull-up and direction select pin mode
// R8 - bit 7 slows top eight-bit pins
// R9 - bit 6 slows all five-bit pins
// R10 - slow edge leaves pin mode alone
// R11 - output pins read their latch
// R12 - interrupt routes blocked on output pins
// R13 - capture input low while pin outputs
// R14 - analog select forces input, no pull-up
// R15 - pins sampled, latches written on clock
module dgp_port #(
	parameter int ADDR_W = 8 // Byte address width of the slave
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Eight-bit port pads
	input  wire logic [7:0]        wideIn,
	output logic      [7:0]        wideOut,
	output logic      [7:0]        wideOutEn_n,
	output logic      [7:0]        widePullUp,
	output logic      [1:0]        wideSlowEdge,
	// Five-bit port pads
	input  wire logic [4:0]        narrowIn,
	output logic      [4:0]        narrowOut,
	output logic      [4:0]        narrowOutEn_n,
	output logic      [4:0]        narrowPullUp,
	output logic      [4:0]        narrowSlowEdge,
	// Shared functions
	output logic                   mainExtIrqReq,
	output logic                   secondExtIrqReq,
	output logic                   captureIn,
	output logic                   converterPowerOn,
	output logic                   irq
);

	localparam int WA = dgp_pkg::WIDE_PINS;
	localparam int NB = dgp_pkg::NARROW_PINS;
	localparam int EV = dgp_pkg::EVENT_BITS;

	// ****************
	// State
	// ****************
	typedef struct packed {
		logic [WA-1:0] latchA;     // port_a_latch
		logic [NB-1:0] latchB;     // port_b_latch
		logic [WA-1:0] dirA;       // port_a_direction
		logic [NB-1:0] dirB;       // Direction part of port_b_direction_slew
		logic          slowA;      // slow_edge_enable_upper_a
		logic          slowB;      // slow_edge_enable_all_b
		logic [WA-1:0] pullA;      // port_a_pullup_enable
		logic [NB-1:0] pullB;      // port_b_pullup_enable
		logic [EV-1:0] irqStatus;  // Sticky events
		logic [EV-1:0] irqMask;    // Event enables
		logic [2:0]    convCtrl;   // Converter power and channel selects
		logic          awHeld;     // Write address captured
		logic [5:0]    awIdx;      // Captured write index
		logic          wHeld;      // Write data captured
		logic [7:0]    wData;      // Captured low byte
		logic          wLane0;     // Low byte lane enabled
		logic          bValid;     // Write answer pending
		logic [1:0]    bResp;      // Write answer code
		logic          rValid;     // Read answer pending
		logic [7:0]    rData;      // Read byte
		logic [1:0]    rResp;      // Read answer code
		logic          prevMain;   // Last main request level
		logic          prevSecond; // Last second request level
		logic          prevCap;    // Last capture input level
	} dgp_state_t;

	dgp_state_t state;      // Registered state
	dgp_state_t next_state; // Next value

	// ****************
	// Helpers
	// ****************
	// Word index from a byte address; low two bits ignored
	function automatic logic [5:0] dgp_index(input logic [ADDR_W-1:0] addr);
		dgp_index = addr[7:2];
	endfunction : dgp_index

	// True when the index names a register
	function automatic logic dgp_mapped(input logic [5:0] idx);
		dgp_mapped = (idx == dgp_pkg::IDX_A_LATCH)     || (idx == dgp_pkg::IDX_B_LATCH)
			|| (idx == dgp_pkg::IDX_A_DIRECTION) || (idx == dgp_pkg::IDX_B_DIR_SLEW)
			|| (idx == dgp_pkg::IDX_A_PULLUP)    || (idx == dgp_pkg::IDX_B_PULLUP)
			|| (idx == dgp_pkg::IDX_IRQ_STATUS)  || (idx == dgp_pkg::IDX_IRQ_MASK)
			|| (idx == dgp_pkg::IDX_CONVERTER);
	endfunction : dgp_mapped

	// ****************
	// Pin banks
	// ****************
	logic [WA-1:0] smpA;      // Sampled wide pins
	logic [WA-1:0] effDirA;   // Wide direction in force
	logic [WA-1:0] readA;     // Wide read-back
	logic [NB-1:0] smpB;      // Sampled narrow pins
	logic [NB-1:0] effDirB;   // Narrow direction in force
	logic [NB-1:0] readB;     // Narrow read-back
	logic [NB-1:0] forceB;    // Narrow pins taken by the converter

	// R14 - selected channels with converter on
	always_comb begin
		forceB = '0;
		forceB[dgp_pkg::CH4_PIN] = state.convCtrl[dgp_pkg::CONV_ON_BIT]
			& state.convCtrl[dgp_pkg::CONV_CH4_BIT];
		forceB[dgp_pkg::CH5_PIN] = state.convCtrl[dgp_pkg::CONV_ON_BIT]
			& state.convCtrl[dgp_pkg::CONV_CH5_BIT];
	end

	// R1 - eight-bit pin bank
	dgp_pin_bank #(
		.WIDTH(WA)
	) u_bank_a (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.pinIn      (wideIn),
		.latchVal   (state.latchA),
		.dirVal     (state.dirA),
		.pullVal    (state.pullA),
		.analogForce('0),
		.sampled    (smpA),
		.effDir     (effDirA),
		.readVal    (readA),
		.padOut     (wideOut),
		.padOutEn_n (wideOutEn_n),
		.padPullUp  (widePullUp)
	);

	// R2 - five-bit pin bank
	dgp_pin_bank #(
		.WIDTH(NB)
	) u_bank_b (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.pinIn      (narrowIn),
		.latchVal   (state.latchB),
		.dirVal     (state.dirB),
		.pullVal    (state.pullB),
		.analogForce(forceB),
		.sampled    (smpB),
		.effDir     (effDirB),
		.readVal    (readB),
		.padOut     (narrowOut),
		.padOutEn_n (narrowOutEn_n),
		.padPullUp  (narrowPullUp)
	);

	// ****************
	// Shared pin functions
	// ****************
	// R12 - route gated by direction
	// Requests are active high for a pin pulled low while it is an input
	assign mainExtIrqReq   = |(~smpA[3:0] & ~effDirA[3:0]);
	assign secondExtIrqReq = ~smpA[4] & ~effDirA[4];

	// R13 - capture low on output pin
	assign captureIn = smpB[0] & ~effDirB[0];

	// R8 - slow top two pins
	// R10 - separate from pin mode
	assign wideSlowEdge   = {2{state.slowA}};
	// R9 - slow all narrow pins
	assign narrowSlowEdge = {NB{state.slowB}};

	assign converterPowerOn = state.convCtrl[dgp_pkg::CONV_ON_BIT];

	// ****************
	// Read multiplexer
	// ****************
	logic [5:0] rdIdx;  // Index of the read being taken
	logic [7:0] rdByte; // Byte it returns

	// Pull-up registers are write only and read as zero
	always_comb begin
		rdIdx  = dgp_index(s_axi_araddr);
		rdByte = '0;
		unique case (rdIdx)
			dgp_pkg::IDX_A_LATCH:     rdByte = readA;
			dgp_pkg::IDX_B_LATCH:     rdByte = {3'b000, readB};
			dgp_pkg::IDX_A_DIRECTION: rdByte = state.dirA;
			// Stored direction is shown, not the converter override
			dgp_pkg::IDX_B_DIR_SLEW:  rdByte = {state.slowA, state.slowB, 1'b0, state.dirB};
			dgp_pkg::IDX_IRQ_STATUS:  rdByte = {5'b0_0000, state.irqStatus};
			dgp_pkg::IDX_IRQ_MASK:    rdByte = {5'b0_0000, state.irqMask};
			dgp_pkg::IDX_CONVERTER:   rdByte = {5'b0_0000, state.convCtrl};
			default:                  rdByte = '0;
		endcase
	end

	// ****************
	// Next state
	// ****************
	logic          doWrite; // Address and data both captured
	logic [EV-1:0] events;  // Events seen this cycle
	logic [EV-1:0] w1c;     // Status bits software clears

	always_comb begin
		next_state = state;
		doWrite    = state.awHeld && state.wHeld && !state.bValid;
		w1c        = '0;
		events     = '0;

		// Capture write address and data in either order
		if (s_axi_awvalid && !state.awHeld) begin
			next_state.awHeld = 1'b1;
			next_state.awIdx  = dgp_index(s_axi_awaddr);
		end
		if (s_axi_wvalid && !state.wHeld) begin
			next_state.wHeld  = 1'b1;
			next_state.wData  = s_axi_wdata[7:0];
			next_state.wLane0 = s_axi_wstrb[0];
		end

		// R15 - latch on write completion
		if (doWrite) begin
			next_state.awHeld = 1'b0;
			next_state.wHeld  = 1'b0;
			next_state.bValid = 1'b1;
			next_state.bResp  = dgp_mapped(state.awIdx) ? dgp_pkg::RESP_OKAY
				: dgp_pkg::RESP_SLV;
			// Only the low lane carries register bits
			if (state.wLane0) begin
				unique case (state.awIdx)
					dgp_pkg::IDX_A_LATCH:     next_state.latchA = state.wData;
					dgp_pkg::IDX_B_LATCH:     next_state.latchB = state.wData[NB-1:0];
					dgp_pkg::IDX_A_DIRECTION: next_state.dirA   = state.wData;
					dgp_pkg::IDX_B_DIR_SLEW: begin
						next_state.dirB  = state.wData[NB-1:0];
						next_state.slowA = state.wData[dgp_pkg::SLOW_UPPER_A_BIT];
						next_state.slowB = state.wData[dgp_pkg::SLOW_ALL_B_BIT];
					end
					// R5 - wide pull-ups
					dgp_pkg::IDX_A_PULLUP:    next_state.pullA = state.wData;
					// R6 - narrow pull-ups
					dgp_pkg::IDX_B_PULLUP:    next_state.pullB = state.wData[NB-1:0];
					dgp_pkg::IDX_IRQ_STATUS:  w1c = state.wData[EV-1:0];
					dgp_pkg::IDX_IRQ_MASK:    next_state.irqMask = state.wData[EV-1:0];
					dgp_pkg::IDX_CONVERTER:   next_state.convCtrl = state.wData[2:0];
					default:                  next_state.bResp = dgp_pkg::RESP_SLV;
				endcase
			end
		end

		// Write answer stands until the master takes it
		if (state.bValid && s_axi_bready) begin
			next_state.bValid = 1'b0;
		end

		// Read answer one cycle after the address is taken
		if (s_axi_arvalid && !state.rValid) begin
			next_state.rValid = 1'b1;
			next_state.rData  = rdByte;
			next_state.rResp  = dgp_mapped(rdIdx) ? dgp_pkg::RESP_OKAY : dgp_pkg::RESP_SLV;
		end else if (state.rValid && s_axi_rready) begin
			next_state.rValid = 1'b0;
		end

		// Rising request or capture change raises an event
		events[dgp_pkg::EVT_MAIN_BIT]    = mainExtIrqReq & ~state.prevMain;
		events[dgp_pkg::EVT_SECOND_BIT]  = secondExtIrqReq & ~state.prevSecond;
		events[dgp_pkg::EVT_CAPTURE_BIT] = captureIn ^ state.prevCap;
		next_state.prevMain   = mainExtIrqReq;
		next_state.prevSecond = secondExtIrqReq;
		next_state.prevCap    = captureIn;

		// A new event beats a clear in the same cycle
		next_state.irqStatus = (state.irqStatus & ~w1c) | events;
	end

	// ****************
	// State register
	// ****************
	// Latches have no reset so their contents ride through a reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			// R3 - directions cleared, latches kept
			state.dirA       <= dgp_pkg::RST_BYTE;
			state.dirB       <= '0;
			state.slowA      <= 1'b0;
			state.slowB      <= 1'b0;
			state.pullA      <= dgp_pkg::RST_BYTE;
			state.pullB      <= '0;
			state.irqStatus  <= '0;
			state.irqMask    <= '0;
			state.convCtrl   <= '0;
			state.awHeld     <= 1'b0;
			state.awIdx      <= '0;
			state.wHeld      <= 1'b0;
			state.wData      <= dgp_pkg::RST_BYTE;
			state.wLane0     <= 1'b0;
			state.bValid     <= 1'b0;
			state.bResp      <= dgp_pkg::RESP_OKAY;
			state.rValid     <= 1'b0;
			state.rData      <= dgp_pkg::RST_BYTE;
			state.rResp      <= dgp_pkg::RESP_OKAY;
			state.prevMain   <= 1'b0;
			state.prevSecond <= 1'b0;
			state.prevCap    <= 1'b1; // Matches the idle-high pin sample
		end else begin
			state <= next_state;
		end
	end

	// ****************
	// Bus outputs and interrupt
	// ****************
	assign s_axi_awready = !state.awHeld;
	assign s_axi_wready  = !state.wHeld;
	assign s_axi_bvalid  = state.bValid;
	assign s_axi_bresp   = state.bResp;
	assign s_axi_arready = !state.rValid;
	assign s_axi_rvalid  = state.rValid;
	assign s_axi_rdata   = {24'h00_0000, state.rData};
	assign s_axi_rresp   = state.rResp;

	// Level output while any unmasked flag stands
	assign irq = |(state.irqStatus & state.irqMask);

endmodule : dgp_port
`default_nettype wire

// ===== dgp_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port relations watched from the outside
// ****************
module dgp_port_checker #(
	parameter int ADDR_W = 8
) (
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic [7:0]        wideOut,
	input wire logic [7:0]        wideOutEn_n,
	input wire logic [7:0]        widePullUp,
	input wire logic [1:0]        wideSlowEdge,
	input wire logic [4:0]        narrowOut,
	input wire logic [4:0]        narrowOutEn_n,
	input wire logic [4:0]        narrowPullUp,
	input wire logic [4:0]        narrowSlowEdge,
	input wire logic              mainExtIrqReq,
	input wire logic              secondExtIrqReq,
	input wire logic              captureIn,
	input wire logic              irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Directions come back cleared, so nothing is driven
	chk_reset_dirs: assert property ($fell(rst) |-> wideOutEn_n == 8'hff && narrowOutEn_n == 5'h1f)
		else $error("pins driven right after reset");
	// A driven pin never raises an interrupt request; one cycle allowed for sampling
	chk_main_blocked: assert property ((wideOutEn_n[3:0] == 4'h0)[*2] |-> !mainExtIrqReq)
		else $error("main request from driven pins");
	chk_second_blocked: assert property ((!wideOutEn_n[4])[*2] |-> !secondExtIrqReq)
		else $error("second request from driven pin");
	chk_capture_low: assert property ((!narrowOutEn_n[0])[*2] |-> !captureIn)
		else $error("capture input not low on output pin");
	// Open drain may only pull low
	chk_od_high: assert property (((widePullUp & ~wideOutEn_n & wideOut) == 8'h00) && ((narrowPullUp & ~narrowOutEn_n & narrowOut) == 5'h00))
		else $error("open drain pin driven high");
	chk_slow_pair: assert property (wideSlowEdge == 2'h0 || wideSlowEdge == 2'h3)
		else $error("upper slow edges split");
	chk_slow_all: assert property (narrowSlowEdge == 5'h00 || narrowSlowEdge == 5'h1f)
		else $error("narrow slow edges split");
	chk_slow_mode: assert property ($changed(wideSlowEdge) |-> $stable(wideOutEn_n) && $stable(widePullUp))
		else $error("slow edge change moved pin mode");
	// Answer latencies fixed by the bus contract
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");

	cov_write: cover property (s_axi_bvalid);
	cov_od_release: cover property (widePullUp[0] && wideOutEn_n[0]);
	cov_irq: cover property ($rose(irq));
endmodule : dgp_port_checker

bind dgp_port dgp_port_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ===== dgp_board.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Board around the pads: device drive, then board, then pull-up;
// a floating pin toggles each cycle
// ****************
module dgp_board (
	input wire logic       clk_sys,
	input wire logic [7:0] wideOut,
	input wire logic [7:0] wideOutEn_n,
	input wire logic [7:0] widePullUp,
	input wire logic [7:0] boardWideVal,
	input wire logic [7:0] boardWideEn,
	input wire logic [4:0] narrowOut,
	input wire logic [4:0] narrowOutEn_n,
	input wire logic [4:0] narrowPullUp,
	input wire logic [4:0] boardNarrowVal,
	input wire logic [4:0] boardNarrowEn,
	output logic     [7:0] wideIn,
	output logic     [4:0] narrowIn
);
	logic floatPat = 1'b0; // Stands in for an undriven, unpulled line

	// Toggle so a floating read never settles on a lucky value
	always @(posedge clk_sys) floatPat <= ~floatPat;

	// Resolve each pad level
	always_comb begin
		wideIn = (~wideOutEn_n & wideOut) | (wideOutEn_n & boardWideEn & boardWideVal)
			| (wideOutEn_n & ~boardWideEn & (widePullUp | {8{floatPat}}));
		narrowIn = (~narrowOutEn_n & narrowOut) | (narrowOutEn_n & boardNarrowEn & boardNarrowVal)
			| (narrowOutEn_n & ~boardNarrowEn & (narrowPullUp | {5{floatPat}}));
	end
endmodule : dgp_board
`default_nettype wire

// ===== tb_dual_gpio_port_pullup_slew.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_gpio_port_pullup_slew;
	localparam logic [7:0] A_LAT = {dgp_pkg::IDX_A_LATCH, 2'b00};
	localparam logic [7:0] B_LAT = {dgp_pkg::IDX_B_LATCH, 2'b00};
	localparam logic [7:0] A_DIR = {dgp_pkg::IDX_A_DIRECTION, 2'b00};
	localparam logic [7:0] B_DIR = {dgp_pkg::IDX_B_DIR_SLEW, 2'b00};
	localparam logic [7:0] A_PU  = {dgp_pkg::IDX_A_PULLUP, 2'b00};
	localparam logic [7:0] B_PU  = {dgp_pkg::IDX_B_PULLUP, 2'b00};
	localparam logic [7:0] STAT  = {dgp_pkg::IDX_IRQ_STATUS, 2'b00};
	localparam logic [7:0] MASK  = {dgp_pkg::IDX_IRQ_MASK, 2'b00};
	localparam logic [7:0] CONV  = {dgp_pkg::IDX_CONVERTER, 2'b00};
	localparam logic [1:0] OK    = dgp_pkg::RESP_OKAY;
	// ****************
	// Signals
	// ****************
	logic        clk_sys = 1'b0, rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1; // Always willing to take answers
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  wideIn, wideOut, wideOutEn_n, widePullUp;
	logic [7:0]  boardWideVal = 8'h3c, boardWideEn = 8'hff;
	logic [4:0]  narrowIn, narrowOut, narrowOutEn_n, narrowPullUp, narrowSlowEdge;
	logic [4:0]  boardNarrowVal = 5'h0c, boardNarrowEn = 5'h1f;
	logic [1:0]  wideSlowEdge;
	logic        mainExtIrqReq, secondExtIrqReq, captureIn, converterPowerOn, irq;
	int          errTotal = 0, checked = 0;

	dgp_port #(.ADDR_W(8)) dut (.*);
	dgp_board u_board (.*);

	// Clock of 100 ns
	always #50 clk_sys = ~clk_sys;

	// ****************
	// Tasks
	// ****************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errTotal++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic idle(input int k);
		repeat (k) @(posedge clk_sys);
	endtask : idle

	// Address and data offered together, each dropped once taken
	task automatic put(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (pa || pw) begin
			@(negedge clk_sys);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do @(negedge clk_sys); while (!s_axi_bvalid);
		check(32'(s_axi_bresp), 32'(er));
		check(32'(s_axi_awready), 32'h0001);
		@(posedge clk_sys);
	endtask : put

	task automatic get(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
		logic ta;
		ta = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!ta) begin
			@(negedge clk_sys);
			ta = s_axi_arready;
			@(posedge clk_sys);
		end
		s_axi_arvalid <= 1'b0;
		do @(negedge clk_sys); while (!s_axi_rvalid);
		check(s_axi_rdata, 32'(ed));
		check(32'(s_axi_rresp), 32'(er));
		check(32'(s_axi_arready), 32'h0000);
		@(posedge clk_sys);
	endtask : get

	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// ****************
	// Watchdog: about 130 times the sequence's length
	// ****************
	initial begin
		#(20000 * 100);
		errTotal++;
		print_verdict();
	end

	// ****************
	// Sequence
	// ****************
	initial begin
		idle(12);
		rst <= 1'b0;
		idle(1);
		get(A_DIR, 8'h00, OK);
		get(B_DIR, 8'h00, OK);
		get(A_PU, 8'h00, OK);
		// Output pins read the latch, inputs read the pad
		put(A_LAT, 8'ha5, OK);
		put(A_DIR, 8'h0f, OK);
		boardWideEn <= 8'hf0;
		idle(2);
		get(A_LAT, 8'h35, OK);
		get(A_DIR, 8'h0f, OK);
		check(32'(wideOutEn_n), 32'h00f0);
		check(32'(wideOut), 32'h00a5);
		// Mid-run reset keeps the latch, clears directions
		rst <= 1'b1;
		idle(12);
		rst <= 1'b0;
		idle(1);
		check(32'(wideOutEn_n), 32'h00ff);
		put(A_DIR, 8'hff, OK);
		get(A_LAT, 8'ha5, OK);
		// Narrow port with both slow-edge bits
		put(B_LAT, 8'h1b, OK);
		put(B_DIR, 8'hc3, OK);
		boardNarrowEn <= 5'h1c;
		idle(2);
		get(B_DIR, 8'hc3, OK);
		check(32'(wideSlowEdge), 32'h0003);
		check(32'(narrowSlowEdge), 32'h001f);
		check(32'(narrowOutEn_n), 32'h001c);
		check(32'(narrowOut), 32'h001b);
		check(32'(wideOutEn_n), 32'h0000);
		get(B_LAT, 8'h0f, OK);
		put(B_DIR, 8'h03, OK);
		check(32'(narrowSlowEdge), 32'h0000);
		check(32'(narrowOutEn_n), 32'h001c);
		// Open drain: latch one releases, latch zero sinks
		put(A_PU, 8'h03, OK);
		check(32'(widePullUp), 32'h0003);
		check(32'(wideOutEn_n), 32'h0001);
		get(A_PU, 8'h00, OK);
		get(A_LAT, 8'ha5, OK);
		put(A_PU, 8'h00, OK);
		put(B_PU, 8'h1f, OK);
		check(32'(narrowPullUp), 32'h001f);
		check(32'(narrowOutEn_n), 32'h001f);
		get(B_PU, 8'h00, OK);
		put(B_PU, 8'h00, OK);
		// Converter takes pins 3 and 4, stored direction kept
		put(B_DIR, 8'h0b, OK);
		check(32'(narrowOutEn_n), 32'h0014);
		put(CONV, 8'h03, OK);
		check(32'(narrowOutEn_n), 32'h001c);
		check(32'(converterPowerOn), 32'h0001);
		get(B_DIR, 8'h0b, OK);
		put(B_PU, 8'h08, OK);
		check(32'(narrowPullUp), 32'h0000);
		put(CONV, 8'h00, OK);
		check(32'(narrowPullUp), 32'h0008);
		put(B_PU, 8'h00, OK);
		put(B_DIR, 8'h1b, OK);
		put(CONV, 8'h05, OK);
		check(32'(narrowOutEn_n), 32'h0014);
		put(CONV, 8'h00, OK);
		// Capture input follows pin zero only as an input
		check(32'(captureIn), 32'h0000);
		boardNarrowVal <= 5'h01;
		boardNarrowEn <= 5'h1d;
		put(B_DIR, 8'h1a, OK);
		idle(2);
		check(32'(captureIn), 32'h0001);
		// Interrupt routes, status, mask
		put(A_DIR, 8'h00, OK);
		boardWideVal <= 8'hff;
		boardWideEn <= 8'hff;
		idle(3);
		put(STAT, 8'h07, OK);
		put(MASK, 8'h01, OK);
		check(32'(irq), 32'h0000);
		boardWideVal <= 8'hfe;
		idle(3);
		check(32'(mainExtIrqReq), 32'h0001);
		check(32'(irq), 32'h0001);
		get(STAT, 8'h01, OK);
		put(STAT, 8'h01, OK);
		check(32'(irq), 32'h0000);
		boardWideVal <= 8'hef;
		idle(3);
		check(32'(secondExtIrqReq), 32'h0001);
		get(STAT, 8'h02, OK);
		check(32'(irq), 32'h0000);
		put(A_DIR, 8'h11, OK);
		idle(2);
		check(32'(mainExtIrqReq), 32'h0000);
		check(32'(secondExtIrqReq), 32'h0000);
		// Low lane disabled: write answered but ignored
		s_axi_wstrb <= 4'he;
		put(A_DIR, 8'h00, OK);
		s_axi_wstrb <= 4'hf;
		get(A_DIR, 8'h11, OK);
		// Unmapped place
		put(8'hfc, 8'h55, dgp_pkg::RESP_SLV);
		get(8'hfc, 8'h00, dgp_pkg::RESP_SLV);
		print_verdict();
	end
endmodule : tb_dual_gpio_port_pullup_slew
`default_nettype wire
